// File: include/ebr_defs.svh
// Constants of the external bus release arbiter: timing, reset values and counter constants.
// Assumes one bus state per clock cycle of the 10 MHz system clock.
//
// Summary of operation
// - Sample the external request one state before each bus cycle ends.
// - A request seen at sampling releases the bus after the current cycle.
// - A request missing cycle A's sampling point releases after cycle B.
// - Assert acknowledge 1.5 states after the last bus cycle ends; the code rounds this up to 2 states.
// - Release latency at most longest locked sequence plus about 4.5 states.
// - Never release between the accesses of one logical bus cycle.
// - Atomic test-and-set read and write form one unbreakable cycle.
// - A refresh cycle and the next bus cycle are split only when the bus goes idle between them with no internal request.
// - Internal priority is refresh, then DMA, then CPU; external wins at sampling, but on an idle bus only with no internal request.
// - Refresh while released negates acknowledge; reclaim once request drops.
// - Refresh request halts a burst DMA transfer so refresh goes first.
`ifndef EBR_DEFS_SVH
`define EBR_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define EBR_CLK_PERIOD_NS 100
`define EBR_ACK_DELAY_NS 150
`define EBR_LATENCY_EXTRA_NS 450
// Least time, so rounded up to whole cycles
`define EBR_ACK_DELAY_CYC ((`EBR_ACK_DELAY_NS + `EBR_CLK_PERIOD_NS - 1) / `EBR_CLK_PERIOD_NS)

// ****************************************************************
// Reset values and counter constants
// ****************************************************************
`define EBR_ACK_RESET 1'h1
`define EBR_DRIVE_RESET 1'h1
`define EBR_CNT_ONE 2'h1
`define EBR_CNT_ZERO 2'h0

`endif

// File: include/ebr_pkg.sv
// Types shared by the external bus release arbiter.
// Assumes the bus sequencer reports cycle progress as ebr_cycle_t.
package ebr_pkg;

    // ****************************************************************
    // Arbiter states
    // ****************************************************************
    typedef enum logic [2:0] {
        EBR_OWN      = 3'h0,
        EBR_PEND     = 3'h1,
        EBR_DELAY    = 3'h2,
        EBR_RELEASED = 3'h3,
        EBR_RECLAIM  = 3'h4
    } ebr_state_t;

    // Progress of the bus cycle now running
    typedef struct packed {
        logic active;    // A bus cycle is in progress
        logic sample;    // One state before the cycle ends
        logic last;      // Final state of the cycle
        logic continues; // Next access belongs to the same logical cycle
    } ebr_cycle_t;

    // Grant to the internal masters, at most one high
    typedef struct packed {
        logic refresh;
        logic dma;
        logic cpu;
    } ebr_grant_t;

endpackage

// File: hdl/ebr_arbiter.sv
// External bus release arbiter: hands the shared bus to an external master
// and arbitrates the internal masters (refresh, DMA, CPU) at cycle bounds.
// Assumes inputs are synchronous to clk and one bus state is one clock.
`timescale 1ns/1ps
`include "ebr_defs.svh"

module ebr_arbiter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic extBusRequestN,
    input wire ebr_pkg::ebr_cycle_t cycleIn,
    input wire logic refreshReq,
    input wire logic dmaReq,
    input wire logic dmaBurst,
    input wire logic cpuReq,
    output logic busAckN,
    output logic busDriveEn,
    output ebr_pkg::ebr_grant_t grant,
    output logic dmaHalt
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Fixed priority among the internal masters
    function automatic ebr_pkg::ebr_grant_t pickMaster(input logic rf, input logic dm,
                                                       input logic cp);
        ebr_pkg::ebr_grant_t g;
        g = '0;
        if (rf) begin
            g.refresh = 1'h1;
        end else if (dm) begin
            g.dma = 1'h1;
        end else if (cp) begin
            g.cpu = 1'h1;
        end
        return g;
    endfunction

    ebr_pkg::ebr_state_t state;
    ebr_pkg::ebr_state_t next_state;
    logic [1:0] delayCnt;
    logic [1:0] next_delayCnt;
    logic next_busAckN;
    logic next_busDriveEn;
    ebr_pkg::ebr_grant_t next_grant;
    logic next_dmaHalt;
    logic extReq;
    logic releasable;
    logic boundary;

    assign extReq = ~extBusRequestN;
    // Breaking here would split a logical cycle, an atomic pair or refresh pair
    assign releasable = ~cycleIn.continues & ~grant.refresh;
    assign boundary = cycleIn.last | ~cycleIn.active;

    // ****************************************************************
    // Release state machine
    // ****************************************************************
    // Next state, acknowledge and bus drive
    always_comb begin
        next_state = state;
        next_delayCnt = delayCnt;
        next_busAckN = busAckN;
        next_busDriveEn = busDriveEn;
        unique case (state)
            ebr_pkg::EBR_OWN: begin
                // During an active cycle the request is decided only at the sampling point; a later one waits a cycle
                if (cycleIn.active && cycleIn.sample && extReq && releasable) begin
                    next_state = ebr_pkg::EBR_PEND;
                end else if (!cycleIn.active && extReq && !refreshReq && !dmaReq
                             && !cpuReq) begin
                    // Idle bus: nothing to finish, start the release delay now
                    next_state = ebr_pkg::EBR_DELAY;
                    next_delayCnt = 2'(`EBR_ACK_DELAY_CYC - 1);
                    next_busDriveEn = 1'h0;
                end
            end
            ebr_pkg::EBR_PEND: begin
                if (cycleIn.last) begin
                    next_state = ebr_pkg::EBR_DELAY;
                    next_delayCnt = 2'(`EBR_ACK_DELAY_CYC - 1);
                    next_busDriveEn = 1'h0;
                end
            end
            ebr_pkg::EBR_DELAY: begin
                // Acknowledge lands whole states after the end; total stays bounded
                if (delayCnt == `EBR_CNT_ZERO) begin
                    next_state = ebr_pkg::EBR_RELEASED;
                    next_busAckN = 1'h0;
                end else begin
                    next_delayCnt = delayCnt - `EBR_CNT_ONE;
                end
            end
            ebr_pkg::EBR_RELEASED: begin
                if (refreshReq) begin
                    // Signal the pending refresh; the external master still owns the bus
                    next_state = ebr_pkg::EBR_RECLAIM;
                    next_busAckN = 1'h1;
                end else if (!extReq) begin
                    next_state = ebr_pkg::EBR_OWN;
                    next_busAckN = 1'h1;
                    next_busDriveEn = 1'h1;
                end
            end
            ebr_pkg::EBR_RECLAIM: begin
                if (!extReq) begin
                    next_state = ebr_pkg::EBR_OWN;
                    next_busDriveEn = 1'h1;
                end
            end
            default: begin
                next_state = ebr_pkg::EBR_OWN;
            end
        endcase
    end

    // Register the release state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ebr_pkg::EBR_OWN;
            delayCnt <= `EBR_CNT_ZERO;
            busAckN <= `EBR_ACK_RESET;
            busDriveEn <= `EBR_DRIVE_RESET;
        end else begin
            state <= next_state;
            delayCnt <= next_delayCnt;
            busAckN <= next_busAckN;
            busDriveEn <= next_busDriveEn;
        end
    end

    // ****************************************************************
    // Internal master grant
    // ****************************************************************
    // Grant changes only at a cycle boundary; a pending release takes the bus
    always_comb begin
        next_grant = grant;
        next_dmaHalt = grant.dma & dmaBurst & refreshReq;
        if (next_state != ebr_pkg::EBR_OWN) begin
            next_grant = '0;
        end else if (boundary && !cycleIn.continues) begin
            // Refresh outranks a DMA burst, which dmaHalt stops one clock after refreshReq, boundary or not
            next_grant = pickMaster(refreshReq, dmaReq, cpuReq);
        end
    end

    // Register the grant and halt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grant <= '0;
            dmaHalt <= 1'h0;
        end else begin
            grant <= next_grant;
            dmaHalt <= next_dmaHalt;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ack_timing: assert property (
        (state == ebr_pkg::EBR_PEND && cycleIn.last)
        |-> busAckN ##1 busAckN ##1 busAckN ##1 !busAckN)
    else $error("acknowledge not two states after cycle end");
    a_sample_point: assert property (
        (state == ebr_pkg::EBR_OWN && cycleIn.active && cycleIn.sample && extReq
         && !cycleIn.continues && !grant.refresh) |=> state == ebr_pkg::EBR_PEND)
    else $error("request at sampling point not taken");
    a_release_bound: assert property (
        (state == ebr_pkg::EBR_PEND && cycleIn.last) |=> ##[1:2] !busAckN)
    else $error("release took too long");
    a_logical_cycle: assert property (
        (state == ebr_pkg::EBR_OWN && cycleIn.sample && cycleIn.continues)
        |=> state == ebr_pkg::EBR_OWN)
    else $error("release inside logical cycle");
    a_refresh_pair: assert property (
        (state == ebr_pkg::EBR_OWN && cycleIn.active && grant.refresh)
        |=> state == ebr_pkg::EBR_OWN)
    else $error("release after refresh cycle");
    a_priority_pick: assert property (
        (state == ebr_pkg::EBR_OWN && boundary && !cycleIn.continues && refreshReq
         && !extReq) |=> grant.refresh && !grant.dma && !grant.cpu)
    else $error("refresh not preferred");
    a_reclaim_ack: assert property (
        (state == ebr_pkg::EBR_RELEASED && refreshReq) |=> busAckN && !busDriveEn)
    else $error("acknowledge not negated for refresh");
    a_burst_halt: assert property (
        (grant.dma && dmaBurst && refreshReq) |=> dmaHalt)
    else $error("burst not halted for refresh");
    a_drive_off: assert property (
        (!busAckN || state == ebr_pkg::EBR_RECLAIM) |-> !busDriveEn && grant == '0)
    else $error("driving bus while released");
    // At most one grant high, then holding behaviour between the decision points
    a_grant_onehot: assert property (
        $onehot0(grant))
    else $error("more than one internal master granted");
    a_late_request: assert property (
        (state == ebr_pkg::EBR_OWN && cycleIn.active && !cycleIn.sample)
        |=> state == ebr_pkg::EBR_OWN)
    else $error("request taken away from the sampling point");
    a_pend_wait: assert property (
        (state == ebr_pkg::EBR_PEND && !cycleIn.last)
        |=> state == ebr_pkg::EBR_PEND && busDriveEn)
    else $error("bus given up before the cycle ended");
    a_atomic_lock: assert property (
        (state == ebr_pkg::EBR_OWN && cycleIn.active && cycleIn.continues)
        |=> state == ebr_pkg::EBR_OWN)
    else $error("release inside a locked pair");
    a_ack_hold: assert property (
        (state == ebr_pkg::EBR_RELEASED && extReq && !refreshReq)
        |=> !busAckN && !busDriveEn)
    else $error("bus taken back while still requested");
    a_reclaim_hold: assert property (
        (state == ebr_pkg::EBR_RECLAIM && extReq)
        |=> state == ebr_pkg::EBR_RECLAIM && busAckN && !busDriveEn)
    else $error("bus reclaimed before request dropped");
    a_halt_clear: assert property (
        !(grant.dma && dmaBurst && refreshReq) |=> !dmaHalt)
    else $error("burst halted with no refresh pending");

endmodule

// File: verif/ebr_ext_master.sv
// Model of the external master that borrows the shared bus.
// Assumes the bench raises want for as long as it wants the bus.
`timescale 1ns/1ps
module ebr_ext_master (
    input wire logic clk,
    input wire logic resetn,
    input wire logic want,
    input wire logic busAckN,
    output logic extBusRequestN
);
    logic ackQ;
    logic held;
    // ****
    // Request logic
    // ****
    // Acknowledge may spike, so it goes through one flop and only that copy is used
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ackQ <= 1'h1;
            held <= 1'h0;
            extBusRequestN <= 1'h1;
        end else begin
            ackQ <= busAckN;
            // Only an acknowledge seen while our own request is out counts as a grant
            held <= want && (held || (!ackQ && !extBusRequestN));
            extBusRequestN <= !(want && !(held && ackQ));
        end
    end
endmodule

// File: verif/external_bus_release_arbiter_tb.sv
// Self-checking bench of the external bus release arbiter.
// Assumes one bus state per clock; the bench plays the bus sequencer.
`timescale 1ns/1ps
module external_bus_release_arbiter_tb;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic want = 1'h0;
    logic extBusRequestN;
    ebr_pkg::ebr_cycle_t cycleIn = 4'h0;
    logic refreshReq = 1'h0;
    logic dmaReq = 1'h0;
    logic dmaBurst = 1'h0;
    logic cpuReq = 1'h1;
    logic busAckN;
    logic busDriveEn;
    ebr_pkg::ebr_grant_t grant;
    logic dmaHalt;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'hBC827525;
    int len;
    int k;
    logic [2:0] prioReq [3] = '{3'h7, 3'h3, 3'h1};
    logic [2:0] prioExp [3] = '{3'h4, 3'h2, 3'h1};

    // ****
    // Clock, design and far side
    // ****
    always #50 clk = ~clk;
    ebr_arbiter u_ebr_arbiter (.clk(clk), .resetn(resetn), .extBusRequestN(extBusRequestN),
        .cycleIn(cycleIn), .refreshReq(refreshReq), .dmaReq(dmaReq), .dmaBurst(dmaBurst),
        .cpuReq(cpuReq), .busAckN(busAckN), .busDriveEn(busDriveEn), .grant(grant),
        .dmaHalt(dmaHalt));
    ebr_ext_master u_ebr_ext_master (.clk(clk), .resetn(resetn), .want(want),
        .busAckN(busAckN), .extBusRequestN(extBusRequestN));

    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One access of n states, sampling point in the state before the last
    task automatic access(input int n, input logic cont);
        for (int i = 0; i < n; i++) begin
            cycleIn <= {1'h1, i == n - 2, i == n - 1, cont};
            @(posedge clk);
        end
        cycleIn <= 4'h0;
        #1;
    endtask
    task automatic final_report();
        $display("Checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Bounded wait; a hang ends the run
    task automatic waitDrive(input logic lvl);
        for (int i = 0; i < 20; i++) begin
            if (busDriveEn === lvl) return;
            @(posedge clk);
            #1;
        end
        num_errors++;
        $display("Error drive wait expected %h seen %h", lvl, busDriveEn);
        final_report();
    endtask
    // Give the bus back once acknowledge has been low
    task automatic giveBack();
        repeat (2) @(posedge clk);
        want <= 1'h0;
        waitDrive(1'h1);
        chk("ack back", 3'h1, {2'h0, busAckN});
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        #1;
        chk("reset", 3'h3, {1'h0, busAckN, busDriveEn});
        // Random lengths; refresh kept off while lending the bus
        for (k = 0; k < 6; k++) begin
            len = 2 + ($unsigned($random(seed)) % 4);
            want <= 1'h1;
            @(posedge clk);
            access(len, 1'h0);
            chk("drive", 3'h0, {2'h0, busDriveEn});
            @(posedge clk);
            #1;
            chk("ack early", 3'h1, {2'h0, busAckN});
            repeat (1 + ($unsigned($random(seed)) % 5)) @(posedge clk);
            #1;
            chk("ack", 3'h0, {2'h0, busAckN | busDriveEn});
            giveBack();
        end
        // Request lands after cycle A's sampling point
        fork
            access(3, 1'h0);
            begin
                // Request goes out in A's last state, just past its sampling point
                repeat (1) @(posedge clk);
                want <= 1'h1;
            end
        join
        chk("drive A", 3'h1, {2'h0, busDriveEn});
        access(4, 1'h0);
        chk("drive B", 3'h0, {2'h0, busDriveEn});
        repeat (2) @(posedge clk);
        #1;
        chk("ack B", 3'h0, {2'h0, busAckN});
        giveBack();
        // Atomic pair, then split longword of four accesses
        for (k = 2; k <= 4; k += 2) begin
            want <= 1'h1;
            @(posedge clk);
            for (int j = 1; j < k; j++) begin
                access(2, 1'h1);
                chk("locked", 3'h1, {2'h0, busDriveEn});
            end
            access(2, 1'h0);
            chk("unlocked", 3'h0, {2'h0, busDriveEn});
            giveBack();
        end
        // Refresh wanted while the bus is lent out
        want <= 1'h1;
        @(posedge clk);
        access(2, 1'h0);
        repeat (2) @(posedge clk);
        refreshReq <= 1'h1;
        @(posedge clk);
        #1;
        chk("reclaim", 3'h2, {1'h0, busAckN, busDriveEn});
        waitDrive(1'h1);
        want <= 1'h0;
        // Fixed priority among internal masters
        for (k = 0; k < 3; k++) begin
            {refreshReq, dmaReq, cpuReq} <= prioReq[k];
            access(2, 1'h0);
            chk("grant", prioExp[k], grant);
        end
        // Refresh halts a burst transfer
        {refreshReq, dmaReq, dmaBurst} <= 3'h3;
        access(2, 1'h0);
        refreshReq <= 1'h1;
        want <= 1'h1;
        @(posedge clk);
        #1;
        chk("halt", 3'h1, {2'h0, dmaHalt});
        // Request stands through the refresh cycle; release only after the next one
        refreshReq <= 1'h0;
        access(2, 1'h0);
        chk("refresh pair", 3'h1, {2'h0, busDriveEn});
        access(2, 1'h0);
        chk("after pair", 3'h0, {2'h0, busDriveEn});
        giveBack();
        final_report();
    end
endmodule
